// *** dv/dps_host_model.sv ***
`timescale 1ns/10ps
// ==========================================================
// Host side of the shared debug pins: tester and serial debug host.
module dps_host import dps_pkg::*; (
  input  wire logic clk_i,
  input  wire logic data_out_i,
  input  wire logic data_out_oe_i,
  output logic      test_clock_o,
  output logic      reset_clk_o,
  output logic      mode_break_o,
  output logic      data_in_o
);
  // Pins start with test reset held and no break requested.
  initial begin
    test_clock_o = 1'b0;
    reset_clk_o = 1'b0;
    mode_break_o = 1'b1;
    data_in_o = 1'b0;
  end

  // Static pin levels: reset or serial clock, and mode select or break.
  task automatic set_pins(input logic rc, input logic mb);
    reset_clk_o <= rc;
    mode_break_o <= mb;
  endtask : set_pins

  // One test clock period of 160 ns; output sampled just before the rise.
  task automatic jtag_step(input logic tms, input logic tdi, output logic oe, output logic tdo,
                           output logic stable);
    @(posedge clk_i);
    mode_break_o <= tms;
    data_in_o <= tdi;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    oe = data_out_oe_i;
    tdo = data_out_i;
    stable = 1'b1;
    @(posedge clk_i);
    test_clock_o <= 1'b1;
    // The whole high half is watched, so a change on the rise is caught.
    repeat (8) begin
      @(negedge clk_i);
      if (data_out_i !== tdo || data_out_oe_i !== oe) stable = 1'b0;
    end
    @(posedge clk_i);
    test_clock_o <= 1'b0;
  endtask : jtag_step

  // One 17-bit packet, msb first; the clock stands low outside the packet.
  task automatic bdm_xfer(input logic [16:0] tx, output logic [16:0] rx);
    @(posedge clk_i);
    data_in_o <= tx[16];
    repeat (8) @(posedge clk_i);
    for (int i = 16; i >= 0; i--) begin
      reset_clk_o <= 1'b1;
      repeat (8) @(posedge clk_i);
      reset_clk_o <= 1'b0;
      // After the last bit the line shows the inverse, never a stale bit.
      data_in_o <= (i > 0) ? tx[i-1] : ~tx[0];
      repeat (7) @(posedge clk_i);
      @(negedge clk_i);
      rx[i] = data_out_i;
      @(posedge clk_i);
    end
  endtask : bdm_xfer
endmodule : dps_host

// *** dv/test_debug_port_status_trace.sv ***
`timescale 1ns/10ps
module test_debug_port_status_trace import dps_pkg::*;;
  // ==========================================================
  // Stimulus, observed outputs and bookkeeping.
  logic        clk_i          = 1'b0;
  logic        rstn_i         = 1'b0;
  logic        jtag_select_i  = 1'b1;
  logic [16:0] bdm_tx_word_i  = '0;
  logic [4:0]  ev             = '0;
  logic        ddata_begin_i  = 1'b0;
  logic [1:0]  ddata_bytes_i  = '0;
  logic [31:0] capture_word_i = '0;
  logic [3:0]  break_status_i = '0;
  logic [2:0]  lvl            = '0;
  logic        tck, rclk, mbrk, din, dout, doe, rx_valid, brk_req, sclk, halt_flag;
  logic [16:0] rx_word, tx, dat, rx, prev_tx, last_rx;
  logic [3:0]  code, cap;
  logic        b, prev;
  int          num_errors = 0;
  int          total_checks = 0;
  int          n_valid = 0;
  int          nv, i;

  dps_top dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .jtag_select_i(jtag_select_i), .test_clock_in_i(tck),
    .pin_reset_clk_i(rclk), .pin_mode_break_i(mbrk), .pin_data_in_i(din), .bdm_tx_word_i(bdm_tx_word_i),
    .begin_instr_i(ev[0]), .user_entry_i(ev[1]), .pulse_write_debug_data_instr_i(ev[2]), .taken_branch_i(ev[3]),
    .return_from_exception_i(ev[4]), .ddata_begin_i(ddata_begin_i), .ddata_bytes_i(ddata_bytes_i),
    .capture_word_i(capture_word_i), .break_status_i(break_status_i), .exception_i(lvl[0]),
    .core_stopped_i(lvl[1]), .core_halted_i(lvl[2]), .pin_data_out_o(dout), .pin_data_out_oe_o(doe),
    .bdm_rx_word_o(rx_word), .bdm_rx_valid_o(rx_valid), .manual_break_request_o(brk_req),
    .processor_status_code_o(code), .debug_capture_data_o(cap), .status_sample_clock_o(sclk),
    .core_halted_flag_o(halt_flag));

  dps_host host (.clk_i(clk_i), .data_out_i(dout), .data_out_oe_i(doe), .test_clock_o(tck),
                 .reset_clk_o(rclk), .mode_break_o(mbrk), .data_in_o(din));

  // 100 MHz core clock.
  always #5 clk_i = ~clk_i;

  // ==========================================================
  // Comparison and verdict.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t ns: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Checks made: %0d, mismatches: %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Status helpers; status is read just after the sample clock falls.
  function automatic logic [3:0] ev_code(input int k);
    logic [3:0] t [5];
    t = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h7};
    return t[k];
  endfunction : ev_code

  task automatic fresh();
    @(negedge clk_i);
    if (sclk !== 1'b0) @(negedge clk_i);
  endtask : fresh

  task automatic wait_code(input logic [3:0] e);
    logic [3:0] got;
    got = ~e;
    for (int k = 0; k < 8 && got !== e; k++) begin
      fresh();
      got = code;
    end
    check(got, e);
  endtask : wait_code

  task automatic set_lvl(input logic [2:0] l, input logic [3:0] e);
    @(posedge clk_i);
    lvl <= l;
    wait_code(e);
  endtask : set_lvl

  task automatic capture(input logic [1:0] nb, input logic [31:0] w, input logic [3:0] bs);
    @(posedge clk_i);
    ddata_begin_i <= 1'b1;
    ddata_bytes_i <= nb;
    capture_word_i <= w;
    break_status_i <= bs;
    @(posedge clk_i);
    ddata_begin_i <= 1'b0;
    wait_code({2'b10, nb});
    for (int n = 0; n < (nb + 1) * 2; n++) begin
      fresh();
      check(cap, w[4*n +: 4]);
    end
    fresh();
    check(cap, bs);
  endtask : capture

  task automatic jt(input bit tms, input bit tdi, input bit eoe, input bit etdo, input bit ct);
    logic oe, tdo, stable;
    host.jtag_step(tms, tdi, oe, tdo, stable);
    check(oe, eoe);
    if (ct) check(tdo, etdo);
    check(stable, 1'b1);
    check(brk_req, 1'b0);
  endtask : jt

  // Every status update: flag is the AND of the code, no reserved code.
  always @(negedge clk_i) begin
    if (rstn_i === 1'b1 && sclk === 1'b0) begin
      check(halt_flag, &code);
      check(code inside {4'h2, 4'h6, 4'hD}, 1'b0);
    end
  end

  // Received packets are counted on the falling clock, away from updates.
  always @(negedge clk_i) begin
    if (rx_valid === 1'b1) begin
      n_valid++;
      last_rx = rx_word;
    end
  end

  // The tests need about 2500 cycles; sixteen times that cuts a hang short.
  initial begin
    #400us;
    num_errors++;
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence.
  initial begin
    void'($urandom(37557));
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_i);
      ev <= 5'(1 << k);
      @(posedge clk_i);
      ev <= '0;
      wait_code(ev_code(k));
    end
    for (int r = 0; r < 12; r++) begin
      i = $urandom_range(4);
      @(posedge clk_i);
      ev <= 5'(1 << i);
      @(posedge clk_i);
      ev <= '0;
      wait_code(ev_code(i));
    end
    // Return and branch together: return wins, branch stays pending.
    @(posedge clk_i);
    ev <= 5'h18;
    @(posedge clk_i);
    ev <= '0;
    wait_code(4'h7);
    wait_code(4'h5);
    // Halt over a pending branch, then peel the levels off one by one.
    @(posedge clk_i);
    ev <= 5'h08;
    lvl <= 3'b111;
    @(posedge clk_i);
    ev <= '0;
    wait_code(4'hF);
    set_lvl(3'b011, 4'hE);
    set_lvl(3'b001, 4'hC);
    set_lvl(3'b000, 4'h5);
    wait_code(4'h0);
    for (int n = 0; n < 8; n++) capture(2'(n), (n == 3) ? 32'hFFFFFFFF : $urandom, 4'($urandom));
    // Test port: Shift-IR reads the captured 0001, then bypass shifting.
    host.set_pins(1'b1, 1'b1);
    repeat (10) @(posedge clk_i);
    for (int k = 12; k >= 0; k--) jt(13'b0110000011100 >> k, 1'b1, 13'b0000011110000 >> k,
                                     13'b0000010000000 >> k, 13'b0000011110000 >> k);
    prev = 1'b0;
    for (int k = 0; k < 8; k++) begin
      b = 1'($urandom);
      jt(k == 7, b, 1'b1, prev, 1'b1);
      prev = b;
    end
    jt(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    jt(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    jt(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    jt(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    jt(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    jt(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    // Test reset in mid-shift must release the output with no clock edge.
    @(posedge clk_i);
    host.set_pins(1'b0, 1'b0);
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    check(doe, 1'b0);
    @(posedge clk_i);
    host.set_pins(1'b1, 1'b0);
    jt(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    // Serial debug mode: packets in, responses one packet later.
    @(posedge clk_i);
    jtag_select_i <= 1'b0;
    host.set_pins(1'b0, 1'b1);
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    check(doe, 1'b1);
    for (int p = 0; p < 6; p++) begin
      tx = (p == 1) ? 17'h1FFFF : 17'($urandom);
      dat = (p == 2) ? 17'h00000 : 17'($urandom);
      @(posedge clk_i);
      bdm_tx_word_i <= tx;
      nv = n_valid;
      host.bdm_xfer(dat, rx);
      repeat (4) @(posedge clk_i);
      check(n_valid - nv, 1);
      check(last_rx, dat);
      // The response leaves msb first from the fall after its load, so
      // one packet carries the old word's low bits and the new msb.
      if (p > 0) check(rx, {prev_tx[15:0], tx[16]});
      else check(rx[0], tx[16]);
      prev_tx = tx;
    end
    // Break pin is active low in this mode.
    host.set_pins(1'b0, 1'b0);
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    check(brk_req, 1'b1);
    @(posedge clk_i);
    host.set_pins(1'b0, 1'b1);
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    check(brk_req, 1'b0);
    tally_and_finish();
  end
endmodule : test_debug_port_status_trace

// *** hdl/dps_defs.svh ***
`ifndef DPS_DEFS_SVH
`define DPS_DEFS_SVH
// ==========================================================
// Processor status codes.
`define DPS_PST_CONT   4'h0
`define DPS_PST_BEGIN  4'h1
`define DPS_PST_RSV0   4'h2
`define DPS_PST_USER   4'h3
`define DPS_PST_PULSE  4'h4
`define DPS_PST_BRANCH 4'h5
`define DPS_PST_RSV1   4'h6
`define DPS_PST_RTE    4'h7
`define DPS_PST_DDATA  2'h2
`define DPS_PST_EXCP   4'hC
`define DPS_PST_RSV2   4'hD
`define DPS_PST_STOP   4'hE
`define DPS_PST_HALT   4'hF
// ==========================================================
// Serial port, capture and status event bit constants.
`define DPS_PKT_LAST   5'h10
`define DPS_IR_CAPTURE 4'h1
`define DPS_NIB        4
`define DPS_EV_DDATA   5
`define DPS_EV_RTE     4
`define DPS_EV_BRANCH  3
`define DPS_EV_PULSE   2
`define DPS_EV_USER    1
`define DPS_EV_BEGIN   0
`endif

// *** hdl/dps_pkg.sv ***
package dps_pkg;
  // ==========================================================
  // Test access port controller states, one-hot.
  typedef enum logic [15:0] {
    TLR = 16'h0001, RTI = 16'h0002, SEL_DR = 16'h0004, CAP_DR = 16'h0008,
    SH_DR = 16'h0010, EX1_DR = 16'h0020, PAU_DR = 16'h0040, EX2_DR = 16'h0080,
    UPD_DR = 16'h0100, SEL_IR = 16'h0200, CAP_IR = 16'h0400, SH_IR = 16'h0800,
    EX1_IR = 16'h1000, PAU_IR = 16'h2000, EX2_IR = 16'h4000, UPD_IR = 16'h8000
  } dps_tap_state_t;
endpackage : dps_pkg

// *** hdl/dps_sync3.sv ***
`timescale 1ns/10ps
module dps_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] f1;
    logic [W-1:0] f2;
    logic [W-1:0] f3;
    logic [W-1:0] q;
  } dps_sync_reg_t;
  dps_sync_reg_t r_reg;
  dps_sync_reg_t r_next;
  logic [W-1:0]  agree;

  // ==========================================================
  // A change is accepted only once the second and third stages agree.
  always_comb begin
    r_next    = r_reg;
    agree     = r_reg.f2 ~^ r_reg.f3;
    r_next.f1 = d_i;
    r_next.f2 = r_reg.f1;
    r_next.f3 = r_reg.f2;
    r_next.q  = (agree & r_reg.f3) | (~agree & r_reg.q);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_o = r_reg.q;
endmodule : dps_sync3

// *** hdl/dps_tap.sv ***
`timescale 1ns/10ps
`include "dps_defs.svh"
module dps_tap import dps_pkg::*; #(
  parameter int IR_W = 4
) (
  input  wire logic clk_i,
  input  wire logic jtag_rstn_i,
  input  wire logic tck_rise_i,
  input  wire logic tck_fall_i,
  input  wire logic tms_i,
  input  wire logic tdi_i,
  output logic      tdo_o,
  output logic      tdo_oe_o
);
  typedef struct packed {
    dps_tap_state_t   st;
    logic [IR_W-1:0]  ir_sh;
    logic             byp;
    logic             tdo;
    logic             oe;
  } dps_tap_reg_t;
  dps_tap_reg_t r_reg;
  dps_tap_reg_t r_next;
  logic         shifting;

  // ==========================================================
  // Controller steps on the test clock rise; output moves on its fall.
  always_comb begin
    r_next   = r_reg;
    shifting = (r_reg.st == SH_DR) || (r_reg.st == SH_IR);
    if (tck_rise_i) begin
      unique case (r_reg.st)
        TLR:    r_next.st = tms_i ? TLR : RTI;
        RTI:    r_next.st = tms_i ? SEL_DR : RTI;
        SEL_DR: r_next.st = tms_i ? SEL_IR : CAP_DR;
        CAP_DR: r_next.st = tms_i ? EX1_DR : SH_DR;
        SH_DR:  r_next.st = tms_i ? EX1_DR : SH_DR;
        EX1_DR: r_next.st = tms_i ? UPD_DR : PAU_DR;
        PAU_DR: r_next.st = tms_i ? EX2_DR : PAU_DR;
        EX2_DR: r_next.st = tms_i ? UPD_DR : SH_DR;
        UPD_DR: r_next.st = tms_i ? SEL_DR : RTI;
        SEL_IR: r_next.st = tms_i ? TLR : CAP_IR;
        CAP_IR: r_next.st = tms_i ? EX1_IR : SH_IR;
        SH_IR:  r_next.st = tms_i ? EX1_IR : SH_IR;
        EX1_IR: r_next.st = tms_i ? UPD_IR : PAU_IR;
        PAU_IR: r_next.st = tms_i ? EX2_IR : PAU_IR;
        EX2_IR: r_next.st = tms_i ? UPD_IR : SH_IR;
        UPD_IR: r_next.st = tms_i ? SEL_DR : RTI;
      endcase
      // Serial input is taken on the same rise as the mode select.
      if (r_reg.st == CAP_IR) r_next.ir_sh = IR_W'(`DPS_IR_CAPTURE);
      if (r_reg.st == SH_IR)  r_next.ir_sh = {tdi_i, r_reg.ir_sh[IR_W-1:1]};
      if (r_reg.st == CAP_DR) r_next.byp = 1'b0;
      if (r_reg.st == SH_DR)  r_next.byp = tdi_i;
    end
    // Updating on the fall gives the tester half a period of setup.
    if (tck_fall_i) begin
      r_next.oe  = shifting;
      r_next.tdo = (r_reg.st == SH_IR) ? r_reg.ir_sh[0] : r_reg.byp;
    end
  end

  // The test reset clears the controller without any test clock edge.
  always_ff @(posedge clk_i or negedge jtag_rstn_i) begin
    if (!jtag_rstn_i) begin
      r_reg <= '{st: TLR, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign tdo_o    = r_reg.tdo;
  assign tdo_oe_o = r_reg.oe;

  // ==========================================================
  // Checks on the controller.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!jtag_rstn_i);

  a_tdo_on_fall: assert property ($changed(r_reg.tdo) |-> $past(tck_fall_i))
    else $error("Test output moved without a falling test clock.");
  a_oe_in_shift: assert property ($rose(r_reg.oe) |-> $past(shifting))
    else $error("Test output enabled outside a shift state.");
  a_tms_step: assert property (tck_rise_i && r_reg.st == RTI && tms_i |=> r_reg.st == SEL_DR)
    else $error("Controller did not follow mode select.");
  a_tdi_sample: assert property (tck_rise_i && r_reg.st == SH_DR |=> r_reg.byp == $past(tdi_i))
    else $error("Serial input not sampled on the rise.");
  c_tap_shift: cover property (r_reg.oe ##1 !r_reg.oe);
endmodule : dps_tap

// *** hdl/dps_top.sv ***
`timescale 1ns/10ps
`include "dps_defs.svh"
// Notes on behaviour
// - Select pin routes shared pins to JTAG or debug.
// - Low test reset clears JTAG logic asynchronously.
// - Mode select sampled on test clock rise.
// - Test data input sampled on test clock rise.
// - Test output driven only in shift states.
// - Test output changes only on test clock fall.
// - Debug serial input passes a synchroniser first.
// - Debug serial output comes straight from a register.
// - Break pin asserted requests a processor breakpoint.
// - Status sample clock tells host when to sample.
// - Four-bit capture data shows data and break status.
// - Status code is synchronous, reflects core state.
// - Codes for execute, user, pulse, branch, return.
// - Codes for transfer lengths, exception and stop.
// - Halted flag is the AND of status bits.
// - Code all ones and flag only when halted.
module dps_top import dps_pkg::*; #(
  parameter int PKT_W        = 17,
  parameter int WORD_W       = 32,
  parameter bit REDUCED_PINS = 1'b0
) (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              jtag_select_i,
  input  wire logic              test_clock_in_i,
  input  wire logic              pin_reset_clk_i,
  input  wire logic              pin_mode_break_i,
  input  wire logic              pin_data_in_i,
  input  wire logic [PKT_W-1:0]  bdm_tx_word_i,
  input  wire logic              begin_instr_i,
  input  wire logic              user_entry_i,
  input  wire logic              pulse_write_debug_data_instr_i,
  input  wire logic              taken_branch_i,
  input  wire logic              return_from_exception_i,
  input  wire logic              ddata_begin_i,
  input  wire logic [1:0]        ddata_bytes_i,
  input  wire logic [WORD_W-1:0] capture_word_i,
  input  wire logic [3:0]        break_status_i,
  input  wire logic              exception_i,
  input  wire logic              core_stopped_i,
  input  wire logic              core_halted_i,
  output logic                   pin_data_out_o,
  output logic                   pin_data_out_oe_o,
  output logic [PKT_W-1:0]       bdm_rx_word_o,
  output logic                   bdm_rx_valid_o,
  output logic                   manual_break_request_o,
  output logic [3:0]             processor_status_code_o,
  output logic [3:0]             debug_capture_data_o,
  output logic                   status_sample_clock_o,
  output logic                   core_halted_flag_o
);
  typedef struct packed {
    logic              tck_prev;
    logic              debug_serial_clock_prev;
    logic [4:0]        bit_cnt;
    logic [PKT_W-1:0]  rx_sh;
    logic [PKT_W-1:0]  tx_sh;
    logic [PKT_W-1:0]  rx_word;
    logic              rx_valid;
    logic              brk;
    logic              pout;
    logic              poe;
    logic              sclk;
    logic [5:0]        pend;
    logic [1:0]        bytes;
    logic [WORD_W-1:0] word;
    logic [WORD_W-1:0] dd_sh;
    logic [3:0]        dd_cnt;
    logic [3:0]        pst;
    logic              halted;
    logic [3:0]        ddata;
  } dps_top_reg_t;
  dps_top_reg_t      r_reg;
  dps_top_reg_t      r_next;
  logic [4:0]        sync_q;
  logic              s_jsel;
  logic              s_tck;
  logic              s_rclk;
  logic              s_mbrk;
  logic              s_din;
  logic              jtag_rstn;
  logic              tck_rise;
  logic              tck_fall;
  logic              ds_rise;
  logic              ds_fall;
  logic              tap_tdo;
  logic              tap_oe;
  logic              upd;
  logic [5:0]        ev;
  logic [5:0]        take;
  logic [3:0]        code;
  logic [1:0]        bsel;
  logic [WORD_W-1:0] wsel;

  // ==========================================================
  // Pin synchronisers. Both link clocks are sampled like data, so
  // the mode select and data inputs keep the same latency as edges.
  dps_sync3 #(
    .W (5)
  ) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    ({jtag_select_i, test_clock_in_i, pin_reset_clk_i, pin_mode_break_i, pin_data_in_i}),
    .q_o    (sync_q)
  );

  // Synchronised levels, split for readability.
  assign s_jsel = sync_q[4];
  assign s_tck  = sync_q[3];
  assign s_rclk = sync_q[2];
  assign s_mbrk = sync_q[1];
  assign s_din  = sync_q[0];

  // The shared reset pin acts as test reset only in JTAG mode; in the
  // debug mode the controller is simply held in reset.
  assign jtag_rstn = rstn_i & jtag_select_i & pin_reset_clk_i;

  // Edge pulses of the two link clocks, gated by the active mode.
  assign tck_rise = s_jsel & s_tck & ~r_reg.tck_prev;
  assign tck_fall = s_jsel & ~s_tck & r_reg.tck_prev;
  assign ds_rise  = ~s_jsel & s_rclk & ~r_reg.debug_serial_clock_prev;
  assign ds_fall  = ~s_jsel & ~s_rclk & r_reg.debug_serial_clock_prev;

  // ==========================================================
  // Test access port.
  dps_tap #(
    .IR_W (4)
  ) u_tap (
    .clk_i       (clk_i),
    .jtag_rstn_i (jtag_rstn),
    .tck_rise_i  (tck_rise),
    .tck_fall_i  (tck_fall),
    .tms_i       (s_mbrk),
    .tdi_i       (s_din),
    .tdo_o       (tap_tdo),
    .tdo_oe_o    (tap_oe)
  );

  // ==========================================================
  // Next state of the serial port, the break request and the status.
  always_comb begin
    r_next            = r_reg;
    r_next.tck_prev   = s_tck;
    r_next.debug_serial_clock_prev = s_rclk;
    r_next.rx_valid   = 1'b0;

    // Debug serial port: sample on the rise, drive on the fall.
    if (s_jsel) begin
      r_next.bit_cnt = 5'h00;
    end else if (ds_rise) begin
      r_next.rx_sh = {r_reg.rx_sh[PKT_W-2:0], s_din};
      if (r_reg.bit_cnt == `DPS_PKT_LAST) begin
        r_next.bit_cnt  = 5'h00;
        r_next.rx_word  = {r_reg.rx_sh[PKT_W-2:0], s_din};
        r_next.rx_valid = 1'b1;
        r_next.tx_sh    = bdm_tx_word_i;
      end else begin
        r_next.bit_cnt = r_reg.bit_cnt + 5'h01;
      end
    end else if (ds_fall) begin
      r_next.tx_sh = {r_reg.tx_sh[PKT_W-2:0], 1'b0};
    end

    // Shared output pin: test output in JTAG mode, registered serial
    // output in debug mode.
    if (s_jsel) begin
      r_next.pout = tap_tdo;
      r_next.poe  = tap_oe;
    end else begin
      r_next.poe = 1'b1;
      if (ds_fall) begin
        r_next.pout = r_reg.tx_sh[PKT_W-1];
      end
    end

    // The break pin is active low and only meaningful in debug mode.
    r_next.brk = ~s_jsel & ~s_mbrk;

    // Status runs at half the core rate; it changes as the sample clock
    // falls, so the host sees a steady value at every rising edge.
    r_next.sclk = ~r_reg.sclk;
    upd         = r_reg.sclk;
    ev          = r_reg.pend | {ddata_begin_i, return_from_exception_i, taken_branch_i,
                                pulse_write_debug_data_instr_i, user_entry_i, begin_instr_i};
    bsel        = ddata_begin_i ? ddata_bytes_i : r_reg.bytes;
    wsel        = ddata_begin_i ? capture_word_i : r_reg.word;
    if (ddata_begin_i) begin
      r_next.bytes = ddata_bytes_i;
      r_next.word  = capture_word_i;
    end

    // Priority: halted, stopped, exception, capture, then instruction
    // events. Capture waits until the previous transfer has drained.
    code = `DPS_PST_CONT;
    take = 6'h00;
    if (core_halted_i) begin
      code = `DPS_PST_HALT;
    end else if (core_stopped_i) begin
      code = `DPS_PST_STOP;
    end else if (exception_i) begin
      code = `DPS_PST_EXCP;
    end else if (ev[`DPS_EV_DDATA] && r_reg.dd_cnt == 4'h0) begin
      code = {`DPS_PST_DDATA, bsel};
      take[`DPS_EV_DDATA] = 1'b1;
    end else if (ev[`DPS_EV_RTE]) begin
      code = `DPS_PST_RTE;
      take[`DPS_EV_RTE] = 1'b1;
    end else if (ev[`DPS_EV_BRANCH]) begin
      code = `DPS_PST_BRANCH;
      take[`DPS_EV_BRANCH] = 1'b1;
    end else if (ev[`DPS_EV_PULSE]) begin
      code = `DPS_PST_PULSE;
      take[`DPS_EV_PULSE] = 1'b1;
    end else if (ev[`DPS_EV_USER]) begin
      code = `DPS_PST_USER;
      take[`DPS_EV_USER] = 1'b1;
    end else if (ev[`DPS_EV_BEGIN]) begin
      code = `DPS_PST_BEGIN;
      take[`DPS_EV_BEGIN] = 1'b1;
    end

    // Events that arrive while another is reported stay pending, so a
    // new event of another kind never loses to the clear of an older one.
    if (upd) begin
      r_next.pend   = ev & ~take;
      r_next.pst    = code;
      r_next.halted = &code;
      if (r_reg.dd_cnt != 4'h0) begin
        r_next.ddata  = r_reg.dd_sh[`DPS_NIB-1:0];
        r_next.dd_sh  = {{`DPS_NIB{1'b0}}, r_reg.dd_sh[WORD_W-1:`DPS_NIB]};
        r_next.dd_cnt = r_reg.dd_cnt - 4'h1;
      end else begin
        r_next.ddata = break_status_i;
      end
      if (take[`DPS_EV_DDATA]) begin
        r_next.dd_sh  = wsel;
        r_next.dd_cnt = 4'({2'b00, bsel} + 4'h1) << 1;
      end
    end else begin
      r_next.pend = ev;
    end
  end

  // ==========================================================
  // State register.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs come straight from the state register; on reduced-pin
  // parts the status code and capture data outputs are held at zero.
  assign pin_data_out_o          = r_reg.pout;
  assign pin_data_out_oe_o       = r_reg.poe;
  assign bdm_rx_word_o           = r_reg.rx_word;
  assign bdm_rx_valid_o          = r_reg.rx_valid;
  assign manual_break_request_o  = r_reg.brk;
  assign processor_status_code_o = REDUCED_PINS ? 4'h0 : r_reg.pst;
  assign debug_capture_data_o    = REDUCED_PINS ? 4'h0 : r_reg.ddata;
  assign status_sample_clock_o   = r_reg.sclk;
  assign core_halted_flag_o      = r_reg.halted;

  // ==========================================================
  // Checks on routing, the serial port and the status encoder.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_route_jtag: assert property (s_jsel |=> pin_data_out_o == $past(tap_tdo) && pin_data_out_oe_o == $past(tap_oe))
    else $error("Shared output not routed to the test port.");
  a_dso_hold: assert property (!s_jsel && !ds_fall |=> $stable(pin_data_out_o))
    else $error("Serial output moved without a falling serial clock.");
  a_rx_sync: assert property (ds_rise && r_reg.bit_cnt == `DPS_PKT_LAST |=> bdm_rx_valid_o && bdm_rx_word_o[0] == $past(s_din))
    else $error("Received word does not hold the synchronised bit.");
  a_rx_pulse: assert property (bdm_rx_valid_o |=> !bdm_rx_valid_o)
    else $error("Receive valid held longer than one cycle.");
  a_break_req: assert property ((!s_jsel && !s_mbrk) [*2] |=> manual_break_request_o)
    else $error("Break pin did not raise a break request.");
  a_pst_steady: assert property ($changed(r_reg.pst) |-> !status_sample_clock_o && $past(status_sample_clock_o))
    else $error("Status changed away from the sample clock fall.");
  a_halt_flag: assert property (core_halted_i && status_sample_clock_o |=> core_halted_flag_o && r_reg.pst == `DPS_PST_HALT)
    else $error("Halt not shown by code and flag.");
  a_flag_only: assert property (core_halted_flag_o == (r_reg.pst == `DPS_PST_HALT))
    else $error("Halted flag disagrees with status code.");
  a_stop_code: assert property (core_stopped_i && !core_halted_i && status_sample_clock_o |=> r_reg.pst == `DPS_PST_STOP)
    else $error("Stopped core not reported.");
  a_no_reserved: assert property (!(r_reg.pst inside {`DPS_PST_RSV0, `DPS_PST_RSV1, `DPS_PST_RSV2}))
    else $error("Reserved status code driven.");

  c_bdm_packet: cover property (bdm_rx_valid_o);
  c_halted: cover property ($rose(core_halted_flag_o));
  c_four_bytes: cover property (r_reg.dd_cnt == 4'h8);
  c_branch: cover property (r_reg.pst == `DPS_PST_BRANCH);
endmodule : dps_top
